// *** core/addr_map.sv ***
`timescale 1ns/100ps
// decodes a system bus address into boot rom / sram selects
module addr_map
  import sysreg_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic boot_rom_remap,
  input wire logic [31:0] sys_addr,
  output logic rom_sel_r,
  output logic sram_sel_r
);
  // window decode as named wires
  wire rom_lo = sys_addr <= ROM_LO_TOP;
  wire rom_hi = (sys_addr >= ROM_HI_BASE) && (sys_addr <= ROM_HI_TOP);
  wire sram_hi = (sys_addr >= SRAM_HI_BASE) && (sys_addr <= SRAM_HI_TOP);
  wire sram_lo = sys_addr <= SRAM_LO_TOP;
  wire rom_nxt = boot_rom_remap ? rom_hi : rom_lo;
  wire sram_nxt = boot_rom_remap ? sram_lo : sram_hi;

  // registered selects
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rom_sel_r <= 1'b0;
      sram_sel_r <= 1'b0;
    end else begin
      rom_sel_r <= rom_nxt;
      sram_sel_r <= sram_nxt;
    end
  end

  a_remap_rom: assert property (@(posedge clk) disable iff (!rst_n)
    boot_rom_remap && sys_addr == ROM_HI_BASE |=> rom_sel_r && !sram_sel_r)
    else $error("rom not decoded at high window");
  a_plain_sram: assert property (@(posedge clk) disable iff (!rst_n)
    !boot_rom_remap && sys_addr == SRAM_HI_BASE |=> sram_sel_r && !rom_sel_r)
    else $error("sram not decoded at high window");
endmodule

// *** core/strap_decode.sv ***
`timescale 1ns/100ps
// decodes strap configuration into boot mode and flash divider index
module strap_decode
  import sysreg_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [STRAP_W-1:0] strap_config_field,
  output boot_mode_t boot_mode_r,
  output logic [1:0] flash_rate_r,
  output logic debug_mode_r,
  output logic pkg_debug_pins_r
);
  // boot code decode, low four codes are test mode
  function automatic boot_mode_t boot_of(input logic [2:0] code);
    case (code)
      BOOT_SRAM: boot_of = BM_SRAM;
      BOOT_USB: boot_of = BM_USB;
      BOOT_OTP: boot_of = BM_OTP;
      BOOT_FLASH: boot_of = BM_FLASH;
      default: boot_of = BM_TEST;
    endcase
  endfunction

  wire boot_mode_t boot_nxt = boot_of(strap_config_field[2:0]);
  wire [1:0] rate_nxt = strap_config_field[FLASH_LSB+1:FLASH_LSB];

  // registered outputs; low level on debug straps means debug active
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      boot_mode_r <= BM_TEST;
      flash_rate_r <= FLASH_72M;
      debug_mode_r <= 1'b0;
      pkg_debug_pins_r <= 1'b0;
    end else begin
      boot_mode_r <= boot_nxt;
      flash_rate_r <= rate_nxt;
      debug_mode_r <= !strap_config_field[DEBUG_BIT];
      pkg_debug_pins_r <= !strap_config_field[PKGDBG_BIT];
    end
  end

  a_boot_flash: assert property (@(posedge clk) disable iff (!rst_n)
    strap_config_field[2:0] == BOOT_FLASH |=> boot_mode_r == BM_FLASH)
    else $error("flash boot not decoded");
endmodule

// *** core/sysreg_pkg.sv ***
package sysreg_pkg;
  // register offsets (byte addresses)
  localparam logic [7:0] OFF_IDENT = 8'h00;
  localparam logic [7:0] OFF_POCFG = 8'h04;
  localparam logic [7:0] OFF_CPUCTL = 8'h08;
  localparam logic [7:0] OFF_MISC = 8'h0c;
  localparam logic [7:0] OFF_BLKRST = 8'h14;
  // identification fields
  localparam int VER_LSB = 24;
  localparam int VER_MSB = 27;
  localparam int ID_MSB = 23;
  // power-on configuration field positions
  localparam int REMAP_BIT = 20;
  localparam int STRAP_W = 7;
  localparam int FLASH_LSB = 5;
  localparam int DEBUG_BIT = 4;
  localparam int PKGDBG_BIT = 3;
  localparam logic REMAP_RST = 1'b0;
  // misc control fields
  localparam int WARM_BIT = 1;
  localparam int DETECT_BIT = 0;
  // block reset writable bits: 30,28,27,25,16,11,10,9,8,5,1,0
  localparam logic [31:0] BLKRST_MASK = 32'h5a010f23;
  localparam logic [31:0] BLKRST_RST = 32'h00000000;
  // flash clock rate selections
  localparam logic [1:0] FLASH_72M = 2'h0;
  localparam logic [1:0] FLASH_36M = 2'h1;
  localparam logic [1:0] FLASH_18M = 2'h2;
  localparam logic [1:0] FLASH_50K = 2'h3;
  // boot source codes
  localparam logic [2:0] BOOT_SRAM = 3'h4;
  localparam logic [2:0] BOOT_USB = 3'h5;
  localparam logic [2:0] BOOT_OTP = 3'h6;
  localparam logic [2:0] BOOT_FLASH = 3'h7;
  // memory windows
  localparam logic [31:0] ROM_LO_BASE = 32'h00000000;
  localparam logic [31:0] ROM_LO_TOP = 32'h00007fff;
  localparam logic [31:0] ROM_HI_BASE = 32'h60000000;
  localparam logic [31:0] ROM_HI_TOP = 32'h60007fff;
  localparam logic [31:0] SRAM_HI_BASE = 32'h20000000;
  localparam logic [31:0] SRAM_HI_TOP = 32'h3fffffff;
  localparam logic [31:0] SRAM_LO_TOP = 32'h1fffffff;
  // cpu reset pulse length in cycles
  localparam logic [3:0] CPU_RST_CYCLES = 4'h4;
  // boot mode type
  typedef enum logic [2:0] {
    BM_TEST = 3'b000,
    BM_SRAM = 3'b001,
    BM_USB = 3'b010,
    BM_OTP = 3'b011,
    BM_FLASH = 3'b100
  } boot_mode_t;
endpackage

// *** core/system_config_reset_regs.sv ***
`timescale 1ns/100ps
module system_config_reset_regs
  import sysreg_pkg::*;
#(
  parameter logic [3:0] CHIP_VERSION = 4'h1, // arbitrary value
  parameter logic [23:0] CHIP_ID = 24'h00a5c3, // arbitrary value
  parameter int RST_PULSE = 4
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic [STRAP_W-1:0] strap_pins,
  input wire logic supply_low,
  input wire logic [31:0] sys_addr,
  output logic rom_sel,
  output logic sram_sel,
  output logic cpu_reset_pulse,
  output logic undervolt_warmup,
  output logic undervolt_detect_enable,
  output logic undervolt_reset,
  output logic [31:0] block_reset,
  output boot_mode_t boot_mode,
  output logic [1:0] flash_rate,
  output logic debug_mode,
  output logic pkg_debug_pins
);
  initial begin
    if (RST_PULSE < 1 || RST_PULSE > 15) begin
      $error("RST_PULSE must be 1..15");
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register state
  logic [STRAP_W-1:0] strap_config_field_r; // latched straps, soft writable
  logic boot_rom_remap_r; // remap control
  logic strap_taken_r; // straps captured once after reset release
  logic [3:0] cpu_cnt_r; // remaining cpu reset cycles
  logic warm_r; // warm-up enable
  logic detect_r; // detection enable
  logic [31:0] blk_r; // block reset bits
  logic uv_reset_r; // system reset request

  ////////////////////////////////////////////////////////////////////////////
  // address decode
  wire hit_ident = reg_addr == OFF_IDENT;
  wire hit_pocfg = reg_addr == OFF_POCFG;
  wire hit_cpu = reg_addr == OFF_CPUCTL;
  wire hit_misc = reg_addr == OFF_MISC;
  wire hit_blk = reg_addr == OFF_BLKRST;
  wire wr_pocfg = reg_wr && hit_pocfg;
  wire wr_cpu = reg_wr && hit_cpu;
  wire wr_misc = reg_wr && hit_misc;
  wire wr_blk = reg_wr && hit_blk;

  // writable config bits; debug bit stays as strapped
  localparam logic [STRAP_W-1:0] CFG_WMASK = 7'h6f;
  wire [STRAP_W-1:0] cfg_nxt = (strap_config_field_r & ~CFG_WMASK)
                             | (reg_wdata[STRAP_W-1:0] & CFG_WMASK);

  // assembled read views, reserved bits zero
  wire [31:0] ident_view = {4'h0, CHIP_VERSION, CHIP_ID};
  wire [31:0] pocfg_view = {11'h000, boot_rom_remap_r, 13'h0000,
                            strap_config_field_r};
  wire [31:0] cpu_view = {31'h00000000, cpu_cnt_r != 4'h0};
  wire [31:0] misc_view = {30'h00000000, warm_r, detect_r};
  // unmapped addresses read zero
  wire [31:0] rdata_nxt = hit_ident ? ident_view :
                          hit_pocfg ? pocfg_view :
                          hit_cpu ? cpu_view :
                          hit_misc ? misc_view :
                          hit_blk ? blk_r : 32'h00000000;

  ////////////////////////////////////////////////////////////////////////////
  // read data, valid the cycle after the read strobe only
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 32'h00000000;
    end else begin
      reg_rdata <= reg_rd ? rdata_nxt : 32'h00000000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // power-on configuration: straps are caught on the first edge after release,
  // since an async reset may only load constants
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      strap_config_field_r <= '0;
      strap_taken_r <= 1'b0;
      boot_rom_remap_r <= REMAP_RST;
    end else begin
      strap_taken_r <= 1'b1;
      if (!strap_taken_r) begin
        strap_config_field_r <= strap_pins;
      end else if (wr_pocfg) begin
        strap_config_field_r <= cfg_nxt;
      end
      if (wr_pocfg) begin
        boot_rom_remap_r <= reg_wdata[REMAP_BIT];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // cpu reset: a write of one loads a countdown; the bit reads one while the
  // pulse lasts, then clears itself; a write of zero does nothing
  wire [3:0] pulse_len = 4'(RST_PULSE);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cpu_cnt_r <= 4'h0;
      cpu_reset_pulse <= 1'b0;
    end else begin
      if (wr_cpu && reg_wdata[0]) begin
        cpu_cnt_r <= pulse_len;
      end else if (cpu_cnt_r != 4'h0) begin
        cpu_cnt_r <= cpu_cnt_r - 4'h1;
      end
      cpu_reset_pulse <= (wr_cpu && reg_wdata[0]) || (cpu_cnt_r > 4'h1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // undervolt control; ordering of warm-up and enable is left to software,
  // the detector only acts while both bits are set
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      warm_r <= 1'b0;
      detect_r <= 1'b0;
      uv_reset_r <= 1'b0;
    end else begin
      if (wr_misc) begin
        warm_r <= reg_wdata[WARM_BIT];
        detect_r <= reg_wdata[DETECT_BIT];
      end
      uv_reset_r <= detect_r && warm_r && supply_low;
    end
  end
  assign undervolt_warmup = warm_r;
  assign undervolt_detect_enable = detect_r;
  assign undervolt_reset = uv_reset_r;

  ////////////////////////////////////////////////////////////////////////////
  // block reset bits; only documented positions are writable
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      blk_r <= BLKRST_RST;
    end else if (wr_blk) begin
      blk_r <= reg_wdata & BLKRST_MASK;
    end
  end
  assign block_reset = blk_r;

  ////////////////////////////////////////////////////////////////////////////
  // decoders
  addr_map u_map (
    .clk(clk),
    .rst_n(rst_n),
    .boot_rom_remap(boot_rom_remap_r),
    .sys_addr(sys_addr),
    .rom_sel_r(rom_sel),
    .sram_sel_r(sram_sel)
  );
  strap_decode u_strap (
    .clk(clk),
    .rst_n(rst_n),
    .strap_config_field(strap_config_field_r),
    .boot_mode_r(boot_mode),
    .flash_rate_r(flash_rate),
    .debug_mode_r(debug_mode),
    .pkg_debug_pins_r(pkg_debug_pins)
  );

  ////////////////////////////////////////////////////////////////////////////
  // checks
  a_ident_read: assert property (@(posedge clk) disable iff (!rst_n)
    reg_rd && hit_ident |=> reg_rdata == {4'h0, CHIP_VERSION, CHIP_ID})
    else $error("identity read wrong");
  a_debug_ro: assert property (@(posedge clk) disable iff (!rst_n)
    strap_taken_r && wr_pocfg |=> $stable(strap_config_field_r[DEBUG_BIT]))
    else $error("debug bit changed by write");
  a_cpu_pulse: assert property (@(posedge clk) disable iff (!rst_n)
    wr_cpu && reg_wdata[0] && RST_PULSE == 4 |=> cpu_reset_pulse [*4] ##1 !cpu_reset_pulse)
    else $error("cpu reset pulse length wrong");
  a_cpu_clear: assert property (@(posedge clk) disable iff (!rst_n)
    wr_cpu && reg_wdata[0] |-> ##[1:16] cpu_cnt_r == 4'h0)
    else $error("cpu reset bit never cleared");
  a_cpu_zero: assert property (@(posedge clk) disable iff (!rst_n)
    wr_cpu && !reg_wdata[0] && cpu_cnt_r == 4'h0 |=> !cpu_reset_pulse)
    else $error("zero write started cpu reset");
  a_misc_write: assert property (@(posedge clk) disable iff (!rst_n)
    wr_misc |=> warm_r == $past(reg_wdata[WARM_BIT])
      && detect_r == $past(reg_wdata[DETECT_BIT]))
    else $error("misc write not stored");
  a_uv_reset: assert property (@(posedge clk) disable iff (!rst_n)
    undervolt_reset |-> $past(detect_r) && $past(supply_low))
    else $error("undervolt reset without cause");
  a_uv_fire: assert property (@(posedge clk) disable iff (!rst_n)
    detect_r && warm_r && supply_low |=> undervolt_reset)
    else $error("undervolt reset missed");
  a_blk_hold: assert property (@(posedge clk) disable iff (!rst_n)
    !wr_blk |=> $stable(blk_r))
    else $error("block reset changed without write");
  a_blk_rsvd: assert property (@(posedge clk) disable iff (!rst_n)
    (blk_r & ~BLKRST_MASK) == 32'h00000000)
    else $error("reserved block reset bit set");
  // read data must fall back to zero outside the answer cycle
  a_rdata_idle: assert property (@(posedge clk) disable iff (!rst_n)
    !reg_rd |=> reg_rdata == 32'h00000000)
    else $error("read data outside answer cycle");
  // a block reset write lands masked in the next cycle
  a_blk_write: assert property (@(posedge clk) disable iff (!rst_n)
    wr_blk |=> block_reset == ($past(reg_wdata) & BLKRST_MASK))
    else $error("block reset write not stored");
  // remap follows the written bit
  a_remap_write: assert property (@(posedge clk) disable iff (!rst_n)
    wr_pocfg |=> boot_rom_remap_r == $past(reg_wdata[REMAP_BIT]))
    else $error("remap write not stored");
  // no system reset while the supply is good
  a_uv_quiet: assert property (@(posedge clk) disable iff (!rst_n)
    !supply_low |=> !undervolt_reset)
    else $error("undervolt reset with good supply");
  a_strap_take: assert property (@(posedge clk) disable iff (!rst_n)
    !strap_taken_r |=> strap_config_field_r == $past(strap_pins))
    else $error("straps not captured");
endmodule

// *** tb/test_system_config_reset_regs.sv ***
`timescale 1ns/100ps
module test_system_config_reset_regs
  import sysreg_pkg::*;
;
  // bench-side choices; identity values are arbitrary
  localparam logic [3:0] VER = 4'h3;
  localparam logic [23:0] IDV = 24'h1b2c3d;
  localparam int PULSE = 4; // the pulse-length assertion is written for four cycles
  logic clk, rst_n, reg_wr, reg_rd, supply_low;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, sys_addr, block_reset;
  logic [STRAP_W-1:0] strap_pins;
  logic rom_sel, sram_sel, cpu_reset_pulse, undervolt_warmup;
  logic undervolt_detect_enable, undervolt_reset, debug_mode, pkg_debug_pins;
  logic [1:0] flash_rate;
  boot_mode_t boot_mode;
  int fails, n_tests;
  boot_mode_t boot_exp [8] = '{BM_TEST, BM_TEST, BM_TEST, BM_TEST,
                               BM_SRAM, BM_USB, BM_OTP, BM_FLASH};
  ////////////////////////////////////////////////////////////////////////////
  system_config_reset_regs #(.CHIP_VERSION(VER), .CHIP_ID(IDV), .RST_PULSE(PULSE)) u_dut (
    .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .strap_pins(strap_pins),
    .supply_low(supply_low), .sys_addr(sys_addr), .rom_sel(rom_sel), .sram_sel(sram_sel),
    .cpu_reset_pulse(cpu_reset_pulse), .undervolt_warmup(undervolt_warmup),
    .undervolt_detect_enable(undervolt_detect_enable), .undervolt_reset(undervolt_reset),
    .block_reset(block_reset), .boot_mode(boot_mode), .flash_rate(flash_rate),
    .debug_mode(debug_mode), .pkg_debug_pins(pkg_debug_pins));
  // free-running 25 MHz clock
  always #20 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////
  // shared compare: counts every check, reports a mismatch at once
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
      fails++;
    end
  endtask
  // one-cycle write strobe, launched just after an edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  // reset with given straps; requests wait until the third edge after release
  task automatic do_reset(input logic [6:0] s);
    rst_n <= 1'b0;
    strap_pins <= s;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // identity is fixed and unmapped places read zero
  task automatic t_ident;
    logic [31:0] d;
    rd(OFF_IDENT, d);
    chk("ident", {4'h0, VER, IDV}, d);
    wr(OFF_IDENT, 32'hffffffff);
    rd(OFF_IDENT, d);
    chk("ident after write", {4'h0, VER, IDV}, d);
    wr(8'h10, 32'hffffffff);
    rd(8'h10, d);
    chk("unmapped 10", 32'h0, d);
    rd(8'hfc, d);
    chk("unmapped fc", 32'h0, d);
  endtask
  // every boot code and flash rate; bit 4 keeps its strap level
  task automatic t_config;
    logic [31:0] d;
    logic [2:0] c;
    for (int i = 0; i < 8; i++) begin
      c = 3'(i);
      wr(OFF_POCFG, {25'h0, c[1:0], 1'b0, ~c[0], c});
      rd(OFF_POCFG, d);
      chk("config", {25'h0, c[1:0], 1'b1, ~c[0], c}, d);
      chk("boot mode", 32'(boot_exp[i]), 32'(boot_mode));
      chk("flash rate", 32'(c[1:0]), 32'(flash_rate));
      chk("debug mode", 32'h0, 32'(debug_mode));
      chk("pkg debug", 32'(c[0]), 32'(pkg_debug_pins));
    end
  endtask
  // address windows at each boundary; both sides only at the rom low, sram low and rom high tops
  task automatic map(input logic [31:0] a, input logic r, input logic s);
    @(posedge clk);
    sys_addr <= a;
    @(posedge clk);
    #1 chk("rom/sram select", {30'h0, r, s}, {30'h0, rom_sel, sram_sel});
  endtask
  task automatic t_remap;
    logic [31:0] d;
    map(32'h00000000, 1, 0);
    map(32'h00007fff, 1, 0);
    map(32'h00008000, 0, 0);
    map(32'h20000000, 0, 1);
    map(32'h3fffffff, 0, 1);
    map(32'h60000000, 0, 0);
    // reserved bits set as well; only remap and the writable straps land
    wr(OFF_POCFG, 32'hffffffa5);
    rd(OFF_POCFG, d);
    chk("config remap", 32'h00100035, d);
    map(32'h00000000, 0, 1);
    map(32'h1fffffff, 0, 1);
    map(32'h20000000, 0, 0);
    map(32'h60000000, 1, 0);
    map(32'h60007fff, 1, 0);
    map(32'h60008000, 0, 0);
  endtask
  // a zero write does nothing; a one gives a single bounded pulse
  task automatic t_cpu;
    logic [31:0] d;
    int cnt;
    wr(OFF_CPUCTL, 32'h0);
    repeat (3) @(posedge clk);
    #1 chk("no pulse on zero", 32'h0, 32'(cpu_reset_pulse));
    wr(OFF_CPUCTL, 32'hffffffff);
    #1 chk("pulse starts", 32'h1, 32'(cpu_reset_pulse));
    cnt = 0;
    for (int k = 0; k < 20; k++) begin
      if (cpu_reset_pulse === 1'b1) cnt++;
      @(posedge clk);
      #1;
    end
    chk("pulse length", 32'(PULSE), 32'(cnt));
    rd(OFF_CPUCTL, d);
    chk("cpu bit cleared", 32'h0, d);
  endtask
  // warm-up, wait, detect; reset only with both set and supply low
  task automatic t_undervolt;
    logic [31:0] d;
    supply_low <= 1'b1;
    wr(OFF_MISC, 32'h2);
    repeat (3) @(posedge clk);
    #1 chk("warm only", 32'h2, {30'h0, undervolt_warmup, undervolt_reset});
    repeat (125) @(posedge clk);
    wr(OFF_MISC, 32'h3);
    repeat (2) @(posedge clk);
    #1 chk("undervolt reset", 32'h3, {30'h0, undervolt_detect_enable, undervolt_reset});
    supply_low <= 1'b0;
    repeat (2) @(posedge clk);
    #1 chk("supply good", 32'h0, 32'(undervolt_reset));
    rd(OFF_MISC, d);
    chk("misc", 32'h3, d);
    wr(OFF_MISC, 32'hfffffffe);
    rd(OFF_MISC, d);
    chk("misc reserved", 32'h2, d);
    wr(OFF_MISC, 32'h0);
  endtask
  // every writable block reset bit, reserved ones stay clear
  task automatic t_blkrst;
    logic [31:0] d;
    wr(OFF_BLKRST, 32'hffffffff);
    #1 chk("block reset out", BLKRST_MASK, block_reset);
    rd(OFF_BLKRST, d);
    chk("block reset reg", BLKRST_MASK, d);
    wr(OFF_BLKRST, 32'h0);
    #1 chk("block reset off", 32'h0, block_reset);
  endtask
  // straps taken after a second reset in mid-run
  task automatic t_restrap;
    logic [31:0] d;
    do_reset(7'h0f);
    rd(OFF_POCFG, d);
    chk("strap capture", 32'h0000000f, d);
    chk("debug on", 32'h1, 32'(debug_mode));
    chk("boot flash", 32'(BM_FLASH), 32'(boot_mode));
    rd(OFF_MISC, d);
    chk("misc reset", 32'h0, d);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // main sequence
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    strap_pins = 7'h5a;
    supply_low = 1'b0;
    sys_addr = 32'h0;
    fails = 0;
    n_tests = 0;
    do_reset(7'h5a);
    t_ident();
    t_config();
    t_remap();
    t_cpu();
    t_undervolt();
    t_blkrst();
    t_restrap();
    final_report();
  end
endmodule
